// ### hw/sprc_pkg.sv
// Shared constants for the serial port run control block
package sprc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_RUN_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_WATERMARK = 8'h08;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'h10;
    localparam logic [7:0] ADDR_LINK_STATE = 8'h14;

    // Run control field positions
    localparam int BIT_SCK_OUT_EN = 15;
    localparam int BIT_FS_OUT_EN = 14;
    localparam int BIT_TX_EN = 9;
    localparam int BIT_RX_EN = 8;
    localparam int BIT_TX_RESET = 1;
    localparam int BIT_RX_RESET = 0;
    localparam logic [15:0] RUN_CONTROL_RESET = 16'h0000;

    // Mode register fields
    localparam int BIT_MASTER = 0;
    localparam int FLEN_LSB = 4;
    localparam int FLEN_W = 3;
    localparam int DIV_LSB = 8;
    localparam int DIV_W = 8;
    localparam logic [15:0] MODE_RESET = 16'h0100;
    localparam logic [2:0] FLEN_MAX = 3'h5;

    // Watermark register fields
    localparam int TXWM_LSB = 0;
    localparam int RXWM_LSB = 8;
    localparam int WM_W = 5;
    localparam logic [15:0] WATERMARK_RESET = 16'h0100;

    // Event bits shared by status and mask
    localparam int EV_TX_START = 0;
    localparam int EV_RX_START = 1;
    localparam int EV_FRAME = 2;
    localparam int EV_W = 3;

    // Link state bits
    localparam int ST_TX_ACTIVE = 0;
    localparam int ST_RX_ACTIVE = 1;
    localparam int ST_TX_REQ = 2;
    localparam int ST_RX_REQ = 3;
    localparam int ST_FS_LEVEL = 4;

    // Shortest frame in bit clocks
    localparam logic [8:0] FRAME_BITS_MIN = 9'h008;
endpackage : sprc_pkg

// ### hw/sprc_baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
// Serial clock divider, restartable from a known phase
module sprc_baud_gen #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [DIV_W-1:0] half_period,
    // Generated clock
    output logic sck,
    output logic rise_tick
);
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic next_sck;
    logic next_rise_tick;

    initial begin
        if (DIV_W < 1 || DIV_W > 16) begin
            $error("sprc_baud_gen: DIV_W out of range");
        end
    end

    // Count half periods and toggle the clock
    always_comb begin
        next_cnt = cnt;
        next_sck = sck;
        next_rise_tick = 1'b0;
        if (restart || !run) begin
            next_cnt = '0;
            next_sck = 1'b0;
        end else if (cnt >= half_period) begin
            next_cnt = '0;
            next_sck = !sck;
            next_rise_tick = !sck;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    // Divider state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            sck <= 1'b0;
            rise_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            sck <= next_sck;
            rise_tick <= next_rise_tick;
        end
    end
endmodule // sprc_baud_gen
`default_nettype wire

// ### hw/sprc_run_control.sv
// How it works
// - Serial clock enable low in master mode holds the clock pin at 0.
// - Setting the serial clock enable restarts the baud generator.
// - Serial clock enable high in master mode drives the generated clock on the pin.
// - Frame sync enable low in master mode holds the sync pin at 0.
// - Setting the frame sync enable restarts the frame counter.
// - Module stop clears clock, sync, transmit and receive enables.
// - Reserved control bits read 0; software writes 0 to them.
// - Transmit enable bit 9 lets data leave the transmit pin.
// - Transmit and receive enables act at the next frame sync rise.
// - Active transmit raises requests by watermark, sends once data present.
// - Receive enable bit 8 lets the receive pin be sampled.
// - Active receive raises requests by watermark as data arrives.
// - Transmit reset clears transmit enable.
// - Receive reset clears receive enable.
// - Transmit reset forces transmit pin high and clears transmit state.
// - Receive reset stops reception at once and clears receive state.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module sprc_run_control #(
    parameter int LEVEL_W = 5
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power management
    input wire logic module_stop,
    // Serial pins
    output logic serial_clock_pin,
    output logic serial_clock_pin_oe,
    output logic frame_sync_pin,
    output logic frame_sync_pin_oe,
    input wire logic frame_sync_in,
    output logic serial_transmit_pin,
    input wire logic serial_receive_pin,
    // Shifter and FIFO side
    input wire logic tx_shift_bit,
    input wire logic [LEVEL_W-1:0] tx_fifo_level,
    input wire logic [LEVEL_W-1:0] rx_fifo_level,
    output logic tx_transfer_req,
    output logic rx_transfer_req,
    output logic tx_reset_out,
    output logic rx_reset_out,
    output logic rx_sample_enable,
    output logic rx_bit,
    output logic bit_tick,
    // Interrupt
    output logic irq
);
    initial begin
        if (LEVEL_W < 1 || LEVEL_W > sprc_pkg::WM_W) begin
            $error("sprc_run_control: LEVEL_W out of range");
        end
    end

    // Register state
    logic [15:0] run_control;
    logic [15:0] mode;
    logic [15:0] watermark;
    logic [sprc_pkg::EV_W-1:0] ev_status;
    logic [sprc_pkg::EV_W-1:0] ev_mask;
    logic [31:0] next_prdata;
    logic [15:0] next_run_control;
    logic [15:0] next_mode;
    logic [15:0] next_watermark;
    logic [sprc_pkg::EV_W-1:0] next_ev_status;
    logic [sprc_pkg::EV_W-1:0] next_ev_mask;

    // Link state
    logic [7:0] bit_cnt;
    logic [7:0] next_bit_cnt;
    logic fs_master;
    logic next_fs_master;
    logic fs_seen;
    logic next_fs_seen;
    logic tx_active;
    logic next_tx_active;
    logic rx_active;
    logic next_rx_active;
    logic [2:0] fs_sync;
    logic [2:0] next_fs_sync;
    logic fs_slave;
    logic next_fs_slave;
    logic [2:0] rx_sync;
    logic [2:0] next_rx_sync;
    logic next_rx_bit;
    logic tx_pin;
    logic next_tx_pin;

    // Decoded fields
    logic is_master;
    logic sck_en;
    logic fs_en;
    logic tx_en;
    logic rx_en;
    logic tx_rst;
    logic rx_rst;
    logic [7:0] half_period;
    logic [2:0] flen;
    logic [7:0] last_bit;
    logic [LEVEL_W-1:0] tx_wm;
    logic [LEVEL_W-1:0] rx_wm;
    logic wr_access;
    logic rd_setup;
    logic mapped;
    logic sck_en_rise;
    logic fs_en_rise;
    logic baud_sck;
    logic baud_tick;
    logic fs_level;
    logic frame_start;
    logic [sprc_pkg::EV_W-1:0] ev_set;
    logic [8:0] frame_bits;

    assign is_master = mode[sprc_pkg::BIT_MASTER];
    assign sck_en = run_control[sprc_pkg::BIT_SCK_OUT_EN];
    assign fs_en = run_control[sprc_pkg::BIT_FS_OUT_EN];
    assign tx_en = run_control[sprc_pkg::BIT_TX_EN];
    assign rx_en = run_control[sprc_pkg::BIT_RX_EN];
    assign tx_rst = run_control[sprc_pkg::BIT_TX_RESET];
    assign rx_rst = run_control[sprc_pkg::BIT_RX_RESET];
    assign half_period = mode[sprc_pkg::DIV_LSB +: sprc_pkg::DIV_W];
    assign flen = mode[sprc_pkg::FLEN_LSB +: sprc_pkg::FLEN_W];
    assign tx_wm = watermark[sprc_pkg::TXWM_LSB +: LEVEL_W];
    assign rx_wm = watermark[sprc_pkg::RXWM_LSB +: LEVEL_W];

    // Frame length in bit clocks, clipped to the longest frame
    always_comb begin
        if (flen > sprc_pkg::FLEN_MAX) begin
            frame_bits = sprc_pkg::FRAME_BITS_MIN << sprc_pkg::FLEN_MAX;
        end else begin
            frame_bits = sprc_pkg::FRAME_BITS_MIN << flen;
        end
        last_bit = 8'(frame_bits - 9'h001);
    end

    // APB decode; zero wait states
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    always_comb begin
        case (paddr)
            sprc_pkg::ADDR_RUN_CONTROL,
            sprc_pkg::ADDR_MODE,
            sprc_pkg::ADDR_WATERMARK,
            sprc_pkg::ADDR_EVENT_STATUS,
            sprc_pkg::ADDR_EVENT_MASK,
            sprc_pkg::ADDR_LINK_STATE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    // Enable edges written by software
    assign sck_en_rise = wr_access && (paddr == sprc_pkg::ADDR_RUN_CONTROL)
        && pwdata[sprc_pkg::BIT_SCK_OUT_EN] && !sck_en && !module_stop;
    assign fs_en_rise = wr_access && (paddr == sprc_pkg::ADDR_RUN_CONTROL)
        && pwdata[sprc_pkg::BIT_FS_OUT_EN] && !fs_en && !module_stop;

    // Baud rate generator, runs only when the clock output is enabled
    sprc_baud_gen #(
        .DIV_W(sprc_pkg::DIV_W)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(is_master && sck_en),
        .restart(sck_en_rise),
        .half_period(half_period),
        .sck(baud_sck),
        .rise_tick(baud_tick)
    );

    // Frame sync level and frame boundary; slave takes the input pin
    assign fs_level = is_master ? fs_master : fs_slave;
    assign frame_start = fs_level && !fs_seen;
    assign ev_set = {frame_start,
                     frame_start && rx_en && !rx_active && !rx_rst,
                     frame_start && tx_en && !tx_active && !tx_rst};

    // Register file next values
    always_comb begin
        next_run_control = run_control;
        next_mode = mode;
        next_watermark = watermark;
        next_ev_mask = ev_mask;
        next_ev_status = ev_status;
        next_prdata = prdata;
        if (wr_access) begin
            case (paddr)
                sprc_pkg::ADDR_RUN_CONTROL: begin
                    next_run_control = '0;
                    next_run_control[sprc_pkg::BIT_SCK_OUT_EN] = pwdata[sprc_pkg::BIT_SCK_OUT_EN];
                    next_run_control[sprc_pkg::BIT_FS_OUT_EN] = pwdata[sprc_pkg::BIT_FS_OUT_EN];
                    next_run_control[sprc_pkg::BIT_TX_EN] = pwdata[sprc_pkg::BIT_TX_EN];
                    next_run_control[sprc_pkg::BIT_RX_EN] = pwdata[sprc_pkg::BIT_RX_EN];
                    next_run_control[sprc_pkg::BIT_TX_RESET] = pwdata[sprc_pkg::BIT_TX_RESET];
                    next_run_control[sprc_pkg::BIT_RX_RESET] = pwdata[sprc_pkg::BIT_RX_RESET];
                end
                sprc_pkg::ADDR_MODE: begin
                    next_mode = '0;
                    next_mode[sprc_pkg::BIT_MASTER] = pwdata[sprc_pkg::BIT_MASTER];
                    next_mode[sprc_pkg::FLEN_LSB +: sprc_pkg::FLEN_W] =
                        pwdata[sprc_pkg::FLEN_LSB +: sprc_pkg::FLEN_W];
                    next_mode[sprc_pkg::DIV_LSB +: sprc_pkg::DIV_W] =
                        pwdata[sprc_pkg::DIV_LSB +: sprc_pkg::DIV_W];
                end
                sprc_pkg::ADDR_WATERMARK: begin
                    next_watermark = '0;
                    next_watermark[sprc_pkg::TXWM_LSB +: LEVEL_W] =
                        pwdata[sprc_pkg::TXWM_LSB +: LEVEL_W];
                    next_watermark[sprc_pkg::RXWM_LSB +: LEVEL_W] =
                        pwdata[sprc_pkg::RXWM_LSB +: LEVEL_W];
                end
                sprc_pkg::ADDR_EVENT_STATUS: begin
                    next_ev_status = ev_status & ~pwdata[sprc_pkg::EV_W-1:0];
                end
                sprc_pkg::ADDR_EVENT_MASK: begin
                    next_ev_mask = pwdata[sprc_pkg::EV_W-1:0];
                end
                default: begin
                    next_mode = mode;
                end
            endcase
        end
        // Hardware events win over a clear in the same cycle
        next_ev_status = next_ev_status | ev_set;
        // Resets clear their own enables
        if (next_run_control[sprc_pkg::BIT_TX_RESET]) begin
            next_run_control[sprc_pkg::BIT_TX_EN] = 1'b0;
        end
        if (next_run_control[sprc_pkg::BIT_RX_RESET]) begin
            next_run_control[sprc_pkg::BIT_RX_EN] = 1'b0;
        end
        if (module_stop) begin
            next_run_control[sprc_pkg::BIT_SCK_OUT_EN] = 1'b0;
            next_run_control[sprc_pkg::BIT_FS_OUT_EN] = 1'b0;
            next_run_control[sprc_pkg::BIT_TX_EN] = 1'b0;
            next_run_control[sprc_pkg::BIT_RX_EN] = 1'b0;
        end
        // Read data captured in the setup phase
        if (rd_setup) begin
            next_prdata = '0;
            case (paddr)
                sprc_pkg::ADDR_RUN_CONTROL: next_prdata[15:0] = run_control;
                sprc_pkg::ADDR_MODE: next_prdata[15:0] = mode;
                sprc_pkg::ADDR_WATERMARK: next_prdata[15:0] = watermark;
                sprc_pkg::ADDR_EVENT_STATUS: next_prdata[sprc_pkg::EV_W-1:0] = ev_status;
                sprc_pkg::ADDR_EVENT_MASK: next_prdata[sprc_pkg::EV_W-1:0] = ev_mask;
                sprc_pkg::ADDR_LINK_STATE: begin
                    next_prdata[sprc_pkg::ST_TX_ACTIVE] = tx_active;
                    next_prdata[sprc_pkg::ST_RX_ACTIVE] = rx_active;
                    next_prdata[sprc_pkg::ST_TX_REQ] = tx_transfer_req;
                    next_prdata[sprc_pkg::ST_RX_REQ] = rx_transfer_req;
                    next_prdata[sprc_pkg::ST_FS_LEVEL] = fs_level;
                end
                default: next_prdata = '0;
            endcase
        end
    end

    // Register file storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_control <= sprc_pkg::RUN_CONTROL_RESET;
            mode <= sprc_pkg::MODE_RESET;
            watermark <= sprc_pkg::WATERMARK_RESET;
            ev_status <= '0;
            ev_mask <= '0;
            prdata <= '0;
        end else begin
            run_control <= next_run_control;
            mode <= next_mode;
            watermark <= next_watermark;
            ev_status <= next_ev_status;
            ev_mask <= next_ev_mask;
            prdata <= next_prdata;
        end
    end

    // Frame counter, pin synchronisers and run state next values
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_fs_master = fs_master;
        next_fs_seen = fs_level;
        next_tx_active = tx_active;
        next_rx_active = rx_active;
        next_fs_sync = {fs_sync[1:0], frame_sync_in};
        next_rx_sync = {rx_sync[1:0], serial_receive_pin};
        next_fs_slave = fs_slave;
        next_rx_bit = rx_bit;
        if (fs_sync[1] == fs_sync[2]) begin
            next_fs_slave = fs_sync[2];
        end
        if (rx_sync[1] == rx_sync[2]) begin
            next_rx_bit = rx_sync[2];
        end
        if (fs_en_rise || !fs_en) begin
            next_bit_cnt = '0;
            next_fs_master = 1'b0;
        end else if (baud_tick) begin
            next_fs_master = (bit_cnt == 8'h00);
            next_bit_cnt = (bit_cnt >= last_bit) ? 8'h00 : bit_cnt + 8'h01;
        end
        if (frame_start) begin
            next_tx_active = tx_en;
            next_rx_active = rx_en;
        end
        if (tx_rst || module_stop) begin
            next_tx_active = 1'b0;
        end
        if (rx_rst || module_stop) begin
            next_rx_active = 1'b0;
        end
        // Idle and reset both hold the line high
        if (tx_rst || !tx_active || tx_fifo_level == '0) begin
            next_tx_pin = 1'b1;
        end else begin
            next_tx_pin = tx_shift_bit;
        end
    end

    // Link state storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= '0;
            fs_master <= 1'b0;
            fs_seen <= 1'b0;
            tx_active <= 1'b0;
            rx_active <= 1'b0;
            fs_sync <= '0;
            fs_slave <= 1'b0;
            rx_sync <= '0;
            rx_bit <= 1'b0;
            tx_pin <= 1'b1;
        end else begin
            bit_cnt <= next_bit_cnt;
            fs_master <= next_fs_master;
            fs_seen <= next_fs_seen;
            tx_active <= next_tx_active;
            rx_active <= next_rx_active;
            fs_sync <= next_fs_sync;
            fs_slave <= next_fs_slave;
            rx_sync <= next_rx_sync;
            rx_bit <= next_rx_bit;
            tx_pin <= next_tx_pin;
        end
    end

    // Pins: output enables track master mode
    assign serial_clock_pin_oe = is_master;
    assign frame_sync_pin_oe = is_master;
    assign serial_clock_pin = is_master && sck_en && baud_sck;
    assign frame_sync_pin = is_master && fs_en && fs_master;
    assign serial_transmit_pin = tx_rst ? 1'b1 : tx_pin;
    assign bit_tick = baud_tick;

    // Transfer requests and reset strobes toward the FIFO logic
    assign tx_transfer_req = tx_active && !tx_rst && (tx_fifo_level <= tx_wm);
    assign rx_transfer_req = rx_active && !rx_rst && (rx_fifo_level != '0)
        && (rx_fifo_level >= rx_wm);
    assign rx_sample_enable = rx_active && rx_en && !rx_rst;
    assign tx_reset_out = tx_rst;
    assign rx_reset_out = rx_rst;

    // Interrupt: any unmasked sticky event
    assign irq = |(ev_status & ev_mask);
endmodule // sprc_run_control
`default_nettype wire

// ### bench/sprc_run_control_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Port checks for run control
module sprc_run_control_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Power and pins
    input wire logic module_stop,
    input wire logic serial_clock_pin,
    input wire logic serial_clock_pin_oe,
    input wire logic frame_sync_pin,
    input wire logic frame_sync_pin_oe,
    input wire logic serial_transmit_pin,
    // Shifter side
    input wire logic tx_transfer_req,
    input wire logic rx_transfer_req,
    input wire logic tx_reset_out,
    input wire logic rx_reset_out,
    input wire logic rx_sample_enable,
    input wire logic bit_tick
);
    logic sck_en;
    logic fs_en;
    logic next_sck_en;
    logic next_fs_en;
    logic wr_ctl;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the output enables
    assign wr_ctl = psel && penable && pwrite && (paddr == sprc_pkg::ADDR_RUN_CONTROL);
    always_comb begin
        next_sck_en = sck_en;
        next_fs_en = fs_en;
        if (module_stop) begin
            next_sck_en = 1'b0;
            next_fs_en = 1'b0;
        end else if (wr_ctl) begin
            next_sck_en = pwdata[sprc_pkg::BIT_SCK_OUT_EN];
            next_fs_en = pwdata[sprc_pkg::BIT_FS_OUT_EN];
        end
    end
    // Shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_en <= 1'b0;
            fs_en <= 1'b0;
        end else begin
            sck_en <= next_sck_en;
            fs_en <= next_fs_en;
        end
    end

    a_sck_off_low: assert property (!sck_en |-> !serial_clock_pin)
        else $error("clock pin on while off");
    a_fs_off_low: assert property (!fs_en |-> !frame_sync_pin)
        else $error("sync pin on while off");
    a_sck_runs: assert property (sck_en && serial_clock_pin_oe |-> ##[1:520]
        ($changed(serial_clock_pin) || !sck_en || !serial_clock_pin_oe))
        else $error("clock pin stuck");
    a_tick_single: assert property (bit_tick |=> !bit_tick)
        else $error("tick too long");
    a_slave_quiet: assert property (!serial_clock_pin_oe && !frame_sync_pin_oe
        |-> !serial_clock_pin && !frame_sync_pin)
        else $error("pins driven in slave");
    a_tx_reset_pin: assert property (tx_reset_out |-> serial_transmit_pin && !tx_transfer_req)
        else $error("tx busy in reset");
    a_rx_reset_stop: assert property (rx_reset_out |-> !rx_transfer_req && !rx_sample_enable)
        else $error("rx busy in reset");
    a_stop_quiet: assert property (module_stop [*3] |->
        !rx_sample_enable && !serial_clock_pin && !frame_sync_pin)
        else $error("busy in stop");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_err_unmapped: assert property (psel && penable && paddr > sprc_pkg::ADDR_LINK_STATE
        |-> pslverr)
        else $error("unmapped without error");
endmodule // sprc_run_control_properties

bind sprc_run_control sprc_run_control_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .module_stop(module_stop),
    .serial_clock_pin(serial_clock_pin), .serial_clock_pin_oe(serial_clock_pin_oe),
    .frame_sync_pin(frame_sync_pin), .frame_sync_pin_oe(frame_sync_pin_oe),
    .serial_transmit_pin(serial_transmit_pin), .tx_transfer_req(tx_transfer_req),
    .rx_transfer_req(rx_transfer_req), .tx_reset_out(tx_reset_out),
    .rx_reset_out(rx_reset_out), .rx_sample_enable(rx_sample_enable), .bit_tick(bit_tick)
);
`default_nettype wire

// ### bench/sprc_codec_model.sv
`timescale 1ns/1ns
`default_nettype none
// Slave-mode peer: frame sync and receive data
module sprc_codec_model (
    // Clock
    input wire logic pclk,
    // Commands from the bench
    input wire logic frame_go,
    input wire logic [3:0] lag,
    // Lines toward the port
    output logic frame_sync,
    output logic rx_data
);
    initial begin
        frame_sync = 1'b0;
        rx_data = 1'b0;
    end
    // One sync pulse per command after a lag; data goes high with it
    always begin
        @(posedge pclk);
        if (frame_go) begin
            repeat (lag) @(posedge pclk);
            frame_sync <= 1'b1;
            rx_data <= 1'b1;
            repeat (4) @(posedge pclk);
            frame_sync <= 1'b0;
        end
    end
endmodule // sprc_codec_model
`default_nettype wire

// ### bench/tb_serial_port_run_control.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_serial_port_run_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic module_stop = 1'b0;
    logic tx_shift_bit = 1'b1;
    logic frame_go = 1'b0;
    logic [3:0] lag = 4'h3;
    logic [4:0] tx_lvl = 5'h00;
    logic [4:0] rx_lvl = 5'h00;
    logic [31:0] prdata;
    logic pready, pslverr, sck, sck_oe, fs, fs_oe, fs_in, txd, rxd;
    logic tx_req, rx_req, tx_rst, rx_rst, rx_en, rx_bit, tick, irq;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    localparam logic [7:0] CTL = sprc_pkg::ADDR_RUN_CONTROL;

    // Clock
    always #5 pclk = ~pclk;

    sprc_run_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .module_stop(module_stop), .serial_clock_pin(sck),
        .serial_clock_pin_oe(sck_oe), .frame_sync_pin(fs), .frame_sync_pin_oe(fs_oe),
        .frame_sync_in(fs_in), .serial_transmit_pin(txd), .serial_receive_pin(rxd),
        .tx_shift_bit(tx_shift_bit), .tx_fifo_level(tx_lvl), .rx_fifo_level(rx_lvl),
        .tx_transfer_req(tx_req), .rx_transfer_req(rx_req), .tx_reset_out(tx_rst),
        .rx_reset_out(rx_rst), .rx_sample_enable(rx_en), .rx_bit(rx_bit), .bit_tick(tick),
        .irq(irq));

    sprc_codec_model u_codec (.pclk(pclk), .frame_go(frame_go), .lag(lag),
        .frame_sync(fs_in), .rx_data(rxd));

    // Verdict
    task summarize;
        $display("checked %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // APB setup, then access until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(a, 1'b0, 32'h0);
        `CHK(nm, e, rd)
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    // Cycles between two rises of tick or sync
    task automatic per(input bit use_fs, output int cnt);
        logic p, c;
        int rises;
        p = 1'b1;
        cnt = 0;
        rises = 0;
        for (int i = 0; i < 300 && rises < 2; i++) begin
            @(posedge pclk);
            #1;
            c = use_fs ? fs : tick;
            if (c && !p) rises++;
            if (rises == 1) cnt++;
            p = c;
        end
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and unmapped access
        rdchk(CTL, 32'h0, "run control");
        rdchk(8'h18, 32'h0, "unmapped");
        `CHK("unmapped error", 1'b1, err)
        $display("test reset done");
        // Slave: enables wait for a frame
        apb(CTL, 1'b1, 32'h0000fffc);
        rdchk(CTL, 32'h0000c300, "reserved");
        settle(6);
        `CHK("slave clock pin", 1'b0, sck)
        `CHK("tx req early", 1'b0, tx_req)
        `CHK("rx early", 1'b0, rx_en)
        @(posedge pclk);
        frame_go <= 1'b1;
        @(posedge pclk);
        frame_go <= 1'b0;
        settle(16);
        `CHK("tx req", 1'b1, tx_req)
        `CHK("rx sample", 1'b1, rx_en)
        `CHK("rx bit", 1'b1, rx_bit)
        rdchk(sprc_pkg::ADDR_LINK_STATE, 32'h7, "link state");
        @(posedge pclk);
        tx_lvl <= 5'h03;
        rx_lvl <= 5'h02;
        tx_shift_bit <= 1'b0;
        settle(3);
        `CHK("tx req full", 1'b0, tx_req)
        `CHK("tx pin data", 1'b0, txd)
        `CHK("rx req", 1'b1, rx_req)
        $display("test slave done");
        // Transmit and receive resets
        apb(CTL, 1'b1, 32'h00000302);
        settle(1);
        `CHK("tx pin in reset", 1'b1, txd)
        `CHK("tx req in reset", 1'b0, tx_req)
        rdchk(CTL, 32'h00000102, "tx en");
        apb(CTL, 1'b1, 32'h00000101);
        settle(1);
        `CHK("rx req in reset", 1'b0, rx_req)
        `CHK("rx sample in reset", 1'b0, rx_en)
        rdchk(CTL, 32'h00000001, "rx en");
        apb(CTL, 1'b1, 32'h0);
        $display("test resets done");
        // Master: half period 2 cycles, 8-bit frames
        apb(sprc_pkg::ADDR_MODE, 1'b1, 32'h00000101);
        settle(2);
        `CHK("master clock oe", 1'b1, sck_oe)
        `CHK("clock pin off", 1'b0, sck)
        `CHK("sync pin off", 1'b0, fs)
        apb(CTL, 1'b1, 32'h00008000);
        per(1'b0, n);
        `CHK("bit clock period", 4, n)
        apb(CTL, 1'b1, 32'h0000c000);
        per(1'b1, n);
        `CHK("frame period", 32, n)
        $display("test master done");
        // Module stop clears the enables
        @(posedge pclk);
        module_stop <= 1'b1;
        settle(4);
        rdchk(CTL, 32'h0, "stopped");
        `CHK("stop clock", 1'b0, sck)
        @(posedge pclk);
        module_stop <= 1'b0;
        $display("test stop done");
        // Events: sticky, masked, cleared by writing one
        rdchk(sprc_pkg::ADDR_EVENT_STATUS, 32'h7, "events");
        `CHK("irq masked", 1'b0, irq)
        apb(sprc_pkg::ADDR_EVENT_MASK, 1'b1, 32'h4);
        settle(1);
        `CHK("irq on", 1'b1, irq)
        apb(sprc_pkg::ADDR_EVENT_STATUS, 1'b1, 32'h7);
        settle(1);
        `CHK("irq off", 1'b0, irq)
        rdchk(sprc_pkg::ADDR_EVENT_STATUS, 32'h0, "cleared");
        $display("test events done");
        summarize();
    end
endmodule // tb_serial_port_run_control
`default_nettype wire
